// ===== rtl/xfd_pkg.sv
// constants and types shared by the external-data access block
package xfd_pkg;
    localparam int          RAM_AW        = 10;
    localparam int          RAM_BYTES     = 1024;
    localparam int          XRAM_BYTES    = 1280;
    localparam int          PAGE_W        = 2;
    localparam logic [15:0] USER_RAM_TOP  = 16'h03ff;
    localparam logic [15:0] ALIAS_STEP    = 16'h0400;

    localparam logic [7:0]  SFR_PAGE_SEL  = 8'haa;
    localparam logic [7:0]  SFR_TIMING    = 8'hb6;
    localparam logic [7:0]  SFR_KEY       = 8'hb7;

    localparam logic [7:0]  TIMING_RESET  = 8'h80;
    localparam logic [7:0]  KEY_RESET     = 8'h00;
    localparam logic [7:0]  PAGE_RESET    = 8'h00;
    localparam int          ONESHOT_BIT   = 7;

    localparam logic [7:0]  KEY_FIRST     = 8'ha5;
    localparam logic [7:0]  KEY_SECOND    = 8'hf1;

    localparam logic [1:0]  LOCK_CODE_LOCKED = 2'h0;
    localparam logic [1:0]  LOCK_CODE_KEY1   = 2'h1;
    localparam logic [1:0]  LOCK_CODE_OPEN   = 2'h2;
    localparam logic [1:0]  LOCK_CODE_HARD   = 2'h3;

    typedef enum logic [1:0] {
        LK_LOCKED,
        LK_KEY1,
        LK_OPEN,
        LK_HARD
    } xfd_lock_t;
endpackage

// ===== rtl/xfd_ram_if.sv
// byte-wide port between the access decoder and the user ram
`timescale 1ns/1ps
interface xfd_ram_if;
    logic [xfd_pkg::RAM_AW-1:0] addr;
    logic                       we;
    logic [7:0]                 wdata;
    logic [7:0]                 rdata;

    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// ===== rtl/xfd_user_ram.sv
// 1024-byte user ram held in flip-flops
`timescale 1ns/1ps
module xfd_user_ram (
    input  wire logic clk,
    xfd_ram_if.mem    port
);
    logic [7:0] mem [xfd_pkg::RAM_BYTES];

    // asynchronous read; the decoder registers it for the core
    assign port.rdata = mem[port.addr];

    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
    end
endmodule

// ===== rtl/xfd_access.sv
// external-data space decoder, user ram, flash key lock and flash read one-shot
`timescale 1ns/1ps
// Operation
// R1 - The device holds 1280 bytes of external-data ram, user ram at 0x0000-0x03ff, the rest fifo.
// R2 - The fifo part of that ram is never reachable by an external data move.
// R3 - User ram is served for moves addressed by the data pointer or by an indirect register.
// R4 - A move with an 8-bit address operand takes its high address byte from the page register.
// R5 - The upper 6 address bits are ignored, so the 1024-byte ram repeats over all 64k.
// R6 - Moves go to ram by default and to flash only when flash writes are enabled.
// R7 - With flash writing enabled a move write becomes a flash byte write.
// R8 - Bit 7 of the flash timing register enables the read one-shot and resets to 1.
// R9 - With the one-shot off the sense amps stay on for one whole clock per flash read.
// R10 - Software keeps the one-shot on below a 10 MHz system clock to save power.
// R11 - Software writes only zero to the reserved bits 6-0 of the flash timing register.
// R12 - The page bits select a 256-byte page, unused upper page bits are ignored.
// R13 - A flash access that the lock denies raises a flash-error system reset.
// R14 - Two key bytes in order unlock one flash write or erase; any misstep locks until reset.
// R15 - Reading the key register returns the lock state in bits 1-0.
module xfd_access (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrWdata,
    output logic      [7:0]  sfrRdata,
    input  wire logic [15:0] xmAddr,
    input  wire logic        xmShortAddr,
    input  wire logic        xmWrite,
    input  wire logic        xmRead,
    input  wire logic [7:0]  xmWdata,
    output logic      [7:0]  xmRdata,
    output logic             xmRvalid,
    input  wire logic        flashWriteEnable,
    input  wire logic        flashEraseEnable,
    output logic             flashWriteReq,
    output logic             flashEraseReq,
    output logic      [15:0] flashAddr,
    output logic      [7:0]  flashData,
    output logic             flashErrorReset,
    input  wire logic        flashReadStrobe,
    output logic             senseAmpFullCycle,
    output logic             senseAmpOneShot
);
    xfd_ram_if ramIf ();

    xfd_user_ram uRam (
        .clk  (clk),
        .port (ramIf)
    );

    function automatic logic [1:0] lockCode(input xfd_pkg::xfd_lock_t s);
        unique case (s)
            xfd_pkg::LK_LOCKED: lockCode = xfd_pkg::LOCK_CODE_LOCKED;
            xfd_pkg::LK_KEY1:   lockCode = xfd_pkg::LOCK_CODE_KEY1;
            xfd_pkg::LK_OPEN:   lockCode = xfd_pkg::LOCK_CODE_OPEN;
            xfd_pkg::LK_HARD:   lockCode = xfd_pkg::LOCK_CODE_HARD;
        endcase
    endfunction

    // ---------------- configuration registers
    logic [7:0]                     timingReg;
    logic [7:0]                     next_timingReg;
    logic [xfd_pkg::PAGE_W-1:0]     pageSel;
    logic [xfd_pkg::PAGE_W-1:0]     next_pageSel;
    logic [7:0]                     next_sfrRdata;
    logic                           oneShotOn;
    xfd_pkg::xfd_lock_t             lockState;
    xfd_pkg::xfd_lock_t             next_lockState;

    assign oneShotOn = timingReg[xfd_pkg::ONESHOT_BIT];

    always_comb begin
        next_timingReg = timingReg;
        next_pageSel   = pageSel;
        next_sfrRdata  = sfrRdata;
        if (sfrWrite && sfrAddr == xfd_pkg::SFR_TIMING) begin
            next_timingReg = sfrWdata; // R8
        end
        // only the low page bits are kept; the rest are don't-care
        if (sfrWrite && sfrAddr == xfd_pkg::SFR_PAGE_SEL) begin
            next_pageSel = sfrWdata[xfd_pkg::PAGE_W-1:0]; // R12
        end
        if (sfrRead) begin
            unique case (sfrAddr)
                xfd_pkg::SFR_TIMING:   next_sfrRdata = timingReg;
                xfd_pkg::SFR_KEY:      next_sfrRdata = {6'h00, lockCode(lockState)}; // R15
                xfd_pkg::SFR_PAGE_SEL: next_sfrRdata = {6'h00, pageSel};
                default:               next_sfrRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timingReg <= xfd_pkg::TIMING_RESET; // R8
            pageSel   <= xfd_pkg::PAGE_RESET[xfd_pkg::PAGE_W-1:0];
            sfrRdata  <= xfd_pkg::KEY_RESET;
        end else begin
            timingReg <= next_timingReg;
            pageSel   <= next_pageSel;
            sfrRdata  <= next_sfrRdata;
        end
    end

    // ---------------- address decode and ram path
    logic [15:0] fullAddr;
    logic        flashPath;

    // short operands take their high byte from the page register
    assign fullAddr  = xmShortAddr ? {6'h00, pageSel, xmAddr[7:0]} : xmAddr; // R3 R4
    assign flashPath = flashWriteEnable; // R6

    // dropping the top six bits aliases the ram every 1k and keeps the
    // fifo part of the xram out of reach, since the index never passes 0x3ff
    assign ramIf.addr  = fullAddr[xfd_pkg::RAM_AW-1:0]; // R1 R2 R5
    assign ramIf.we    = xmWrite && !flashPath; // R6
    assign ramIf.wdata = xmWdata;

    logic [7:0] next_xmRdata;
    logic       next_xmRvalid;

    always_comb begin
        next_xmRdata  = xmRdata;
        next_xmRvalid = xmRead;
        if (xmRead) begin
            next_xmRdata = ramIf.rdata; // R3
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xmRdata  <= 8'h00;
            xmRvalid <= 1'b0;
        end else begin
            xmRdata  <= next_xmRdata;
            xmRvalid <= next_xmRvalid;
        end
    end

    // ---------------- flash key lock and write path
    logic        flashTry;
    logic        keyWrite;
    logic        next_flashWriteReq;
    logic        next_flashEraseReq;
    logic [15:0] next_flashAddr;
    logic [7:0]  next_flashData;
    logic        next_flashErrorReset;

    assign flashTry = xmWrite && flashPath;
    assign keyWrite = sfrWrite && sfrAddr == xfd_pkg::SFR_KEY;

    always_comb begin
        next_lockState       = lockState;
        next_flashWriteReq   = 1'b0;
        next_flashEraseReq   = 1'b0;
        next_flashAddr       = flashAddr;
        next_flashData       = flashData;
        next_flashErrorReset = 1'b0;
        // a flash operation outranks a key write in the same cycle
        if (flashTry) begin
            if (lockState == xfd_pkg::LK_OPEN) begin
                next_flashWriteReq = !flashEraseEnable; // R7
                next_flashEraseReq = flashEraseEnable;
                next_flashAddr     = fullAddr;
                next_flashData     = xmWdata; // R7
                next_lockState     = xfd_pkg::LK_LOCKED; // R14
            end else begin
                next_flashErrorReset = 1'b1; // R13
                next_lockState       = xfd_pkg::LK_HARD; // R14
            end
        end else if (keyWrite) begin
            unique case (lockState)
                xfd_pkg::LK_LOCKED: next_lockState = (sfrWdata == xfd_pkg::KEY_FIRST) ?
                                        xfd_pkg::LK_KEY1 : xfd_pkg::LK_HARD; // R14
                xfd_pkg::LK_KEY1:   next_lockState = (sfrWdata == xfd_pkg::KEY_SECOND) ?
                                        xfd_pkg::LK_OPEN : xfd_pkg::LK_HARD; // R14
                xfd_pkg::LK_OPEN:   next_lockState = xfd_pkg::LK_HARD;
                xfd_pkg::LK_HARD:   next_lockState = xfd_pkg::LK_HARD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lockState       <= xfd_pkg::LK_LOCKED;
            flashWriteReq   <= 1'b0;
            flashEraseReq   <= 1'b0;
            flashAddr       <= 16'h0000;
            flashData       <= 8'h00;
            flashErrorReset <= 1'b0;
        end else begin
            lockState       <= next_lockState;
            flashWriteReq   <= next_flashWriteReq;
            flashEraseReq   <= next_flashEraseReq;
            flashAddr       <= next_flashAddr;
            flashData       <= next_flashData;
            flashErrorReset <= next_flashErrorReset;
        end
    end

    // ---------------- flash read sense control
    logic next_senseAmpFullCycle;
    logic next_senseAmpOneShot;

    // the one-shot saves power at slow clocks; a full-cycle enable is
    // only safe for power when the clock is fast
    always_comb begin
        next_senseAmpFullCycle = flashReadStrobe && !oneShotOn; // R9
        next_senseAmpOneShot   = flashReadStrobe && oneShotOn; // R8
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            senseAmpFullCycle <= 1'b0;
            senseAmpOneShot   <= 1'b0;
        end else begin
            senseAmpFullCycle <= next_senseAmpFullCycle;
            senseAmpOneShot   <= next_senseAmpOneShot;
        end
    end

    // ---------------- assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seqKeyFirst;
        keyWrite && !flashTry && sfrWdata == xfd_pkg::KEY_FIRST
            && lockState == xfd_pkg::LK_LOCKED;
    endsequence

    sequence seqKeySecond;
        keyWrite && !flashTry && sfrWdata == xfd_pkg::KEY_SECOND;
    endsequence

    sequence seqRamWrite;
        xmWrite && !flashWriteEnable && !xmShortAddr;
    endsequence

    // one idle cycle between write and read, as the core issues them
    AST_ALIAS_READBACK: assert property ( // R5
        seqRamWrite ##1 !xmWrite ##1 (xmRead && !xmShortAddr && !xmWrite
            && xmAddr == ($past(xmAddr, 2) ^ xfd_pkg::ALIAS_STEP))
        |=> xmRdata == $past(xmWdata, 3))
        else $error("aliased address did not return the written byte");

    AST_READ_VALID: assert property ( // R3
        xmRead |=> xmRvalid && xmRdata == $past(ramIf.rdata))
        else $error("move read returned no valid byte");

    AST_PAGE_HIGH_BYTE: assert property ( // R4
        (xmRead && xmShortAddr) |-> ramIf.addr == {pageSel, xmAddr[7:0]})
        else $error("short operand did not use the page register");

    AST_RAM_BELOW_TOP: assert property ( // R2
        ((xmRead || xmWrite) && !xmShortAddr)
        |-> {6'h00, ramIf.addr} == (xmAddr & xfd_pkg::USER_RAM_TOP))
        else $error("ram index left the user ram window");

    AST_NO_RAM_ON_FLASH: assert property ( // R6
        (xmWrite && flashWriteEnable) |-> !ramIf.we)
        else $error("ram written while flash writes enabled");

    AST_FLASH_WRITE: assert property ( // R7
        (flashTry && !flashEraseEnable && lockState == xfd_pkg::LK_OPEN)
        |=> flashWriteReq && flashData == $past(xmWdata)
            && lockState == xfd_pkg::LK_LOCKED ##1 !flashWriteReq)
        else $error("unlocked move write did not become one flash write");

    AST_FLASH_ERASE: assert property ( // R14
        (flashTry && flashEraseEnable && lockState == xfd_pkg::LK_OPEN)
        |=> flashEraseReq && !flashWriteReq && flashAddr == $past(fullAddr)
            && lockState == xfd_pkg::LK_LOCKED ##1 !flashEraseReq)
        else $error("unlocked move write with erase enabled did not erase once");

    AST_ONESHOT_RESET: assert property ( // R8
        @(posedge clk) disable iff (1'b0)
        rst |=> timingReg == xfd_pkg::TIMING_RESET)
        else $error("flash timing register reset value wrong");

    AST_SENSE_FULL: assert property ( // R9
        (flashReadStrobe && !oneShotOn) |=> senseAmpFullCycle && !senseAmpOneShot)
        else $error("sense amps not held for the read cycle");

    AST_SENSE_ONESHOT: assert property ( // R8
        (flashReadStrobe && oneShotOn) |=> senseAmpOneShot && !senseAmpFullCycle)
        else $error("one-shot sense request missing");

    AST_DENIED_RESET: assert property ( // R13
        (flashTry && lockState != xfd_pkg::LK_OPEN)
        |=> flashErrorReset && !flashWriteReq ##1 !flashErrorReset)
        else $error("denied flash access gave no single error reset");

    AST_KEY_UNLOCK: assert property ( // R14
        seqKeyFirst ##1 (!keyWrite && !flashTry) ##1 seqKeySecond
        |=> lockState == xfd_pkg::LK_OPEN)
        else $error("correct key pair did not unlock");

    AST_KEY_WRONG: assert property ( // R14
        (keyWrite && !flashTry && lockState == xfd_pkg::LK_KEY1
            && sfrWdata != xfd_pkg::KEY_SECOND) |=> lockState == xfd_pkg::LK_HARD)
        else $error("wrong second key did not hard lock");

    AST_HARD_STAYS: assert property ( // R14
        lockState == xfd_pkg::LK_HARD |=> lockState == xfd_pkg::LK_HARD [*2])
        else $error("hard lock released before reset");

    AST_KEY_READBACK: assert property ( // R15
        (sfrRead && sfrAddr == xfd_pkg::SFR_KEY)
        |=> sfrRdata == {6'h00, lockCode($past(lockState))})
        else $error("key register read did not show lock state");
endmodule

// ===== testbench/xfd_core_model.sv
// processor-side model issuing register and external-data move accesses
`timescale 1ns/1ps
module xfd_core_model (
    input  wire logic        clk,
    output logic      [7:0]  sfrAddr,
    output logic             sfrWrite,
    output logic             sfrRead,
    output logic      [7:0]  sfrWdata,
    output logic      [15:0] xmAddr,
    output logic             xmShortAddr,
    output logic             xmWrite,
    output logic             xmRead,
    output logic      [7:0]  xmWdata,
    output logic             flashWriteEnable,
    output logic             flashEraseEnable,
    output logic             flashReadStrobe
);
    initial begin
        {sfrAddr, sfrWrite, sfrRead, sfrWdata} = '0;
        {xmAddr, xmShortAddr, xmWrite, xmRead, xmWdata} = '0;
        {flashWriteEnable, flashEraseEnable, flashReadStrobe} = '0;
    end

    // released lines show the inverse so a stale value is never read as valid
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr  <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
        sfrWdata <= ~d;
    endtask

    // returns once the registered read data has settled
    task automatic sfr_rd(input logic [7:0] a);
        @(posedge clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clk);
        sfrRead <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // returns just after the taking edge, while one-cycle answers still stand
    task automatic mv(input logic wr, input logic sh, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        xmAddr      <= a;
        xmShortAddr <= sh;
        xmWdata     <= d;
        xmWrite     <= wr;
        xmRead      <= ~wr;
        @(posedge clk);
        xmWrite <= 1'b0;
        xmRead  <= 1'b0;
        xmAddr  <= ~a;
        xmWdata <= ~d;
        #1;
    endtask

    task automatic strobe();
        @(posedge clk);
        flashReadStrobe <= 1'b1;
        @(posedge clk);
        flashReadStrobe <= 1'b0;
        #1;
    endtask

    task automatic set_pgm(input logic we, input logic ee);
        @(posedge clk);
        flashWriteEnable <= we;
        flashEraseEnable <= ee;
    endtask

    // reserved bits always written as zero; clock is well above the low-power limit
    task automatic set_oneshot(input logic on);
        sfr_wr(xfd_pkg::SFR_TIMING, {on, 7'h00});
    endtask
endmodule

// ===== testbench/xfd_access_tb.sv
// self-checking bench for the external-data access block
`timescale 1ns/1ps
module xfd_access_tb;
    logic        clk, rst, sfrWrite, sfrRead, xmShortAddr, xmWrite, xmRead, xmRvalid;
    logic        flashWriteEnable, flashEraseEnable, flashWriteReq, flashEraseReq;
    logic        flashErrorReset, flashReadStrobe, senseAmpFullCycle, senseAmpOneShot;
    logic [7:0]  sfrAddr, sfrWdata, sfrRdata, xmWdata, xmRdata, flashData;
    logic [15:0] xmAddr, flashAddr;
    int          nFail = 0;
    int          comparisons = 0;

    xfd_core_model core (.clk(clk), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
        .sfrWdata(sfrWdata), .xmAddr(xmAddr), .xmShortAddr(xmShortAddr), .xmWrite(xmWrite),
        .xmRead(xmRead), .xmWdata(xmWdata), .flashWriteEnable(flashWriteEnable),
        .flashEraseEnable(flashEraseEnable), .flashReadStrobe(flashReadStrobe));

    xfd_access dut (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .xmAddr(xmAddr),
        .xmShortAddr(xmShortAddr), .xmWrite(xmWrite), .xmRead(xmRead), .xmWdata(xmWdata),
        .xmRdata(xmRdata), .xmRvalid(xmRvalid), .flashWriteEnable(flashWriteEnable),
        .flashEraseEnable(flashEraseEnable), .flashWriteReq(flashWriteReq),
        .flashEraseReq(flashEraseReq), .flashAddr(flashAddr), .flashData(flashData),
        .flashErrorReset(flashErrorReset), .flashReadStrobe(flashReadStrobe),
        .senseAmpFullCycle(senseAmpFullCycle), .senseAmpOneShot(senseAmpOneShot));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic reportAndStop();
        if (nFail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
        core.sfr_rd(a);
        chkVal({8'h00, sfrRdata}, {8'h00, exp});
    endtask

    task automatic rdMem(input logic [15:0] a, input logic sh, input logic [7:0] exp);
        core.mv(1'b0, sh, a, 8'h00);
        chkBit(xmRvalid, 1'b1);
        chkVal({8'h00, xmRdata}, {8'h00, exp});
    endtask

    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        nFail++;
        reportAndStop();
    end

    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdReg(xfd_pkg::SFR_TIMING, 8'h80);
        rdReg(xfd_pkg::SFR_KEY, 8'h00);
        rdReg(xfd_pkg::SFR_PAGE_SEL, 8'h00);
        rdReg(8'h55, 8'h00);
        core.mv(1'b1, 1'b0, 16'h0005, 8'h3c);
        rdMem(16'h0405, 1'b0, 8'h3c);
        core.mv(1'b1, 1'b0, 16'hfbff, 8'hc3);
        rdMem(16'h03ff, 1'b0, 8'hc3);
        core.mv(1'b1, 1'b0, 16'h0480, 8'h5a);
        rdMem(16'h0080, 1'b0, 8'h5a);
        core.sfr_wr(xfd_pkg::SFR_PAGE_SEL, 8'hff);
        rdReg(xfd_pkg::SFR_PAGE_SEL, 8'h03);
        core.mv(1'b1, 1'b1, 16'h0012, 8'h77);
        rdMem(16'hfb12, 1'b0, 8'h77);
        rdMem(16'hab12, 1'b1, 8'h77);
        core.strobe();
        chkBit(senseAmpOneShot, 1'b1);
        chkBit(senseAmpFullCycle, 1'b0);
        core.set_oneshot(1'b0);
        rdReg(xfd_pkg::SFR_TIMING, 8'h00);
        core.strobe();
        chkBit(senseAmpFullCycle, 1'b1);
        chkBit(senseAmpOneShot, 1'b0);
        // two key bytes in order, then one flash byte write through a move
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_FIRST);
        rdReg(xfd_pkg::SFR_KEY, 8'h01);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_SECOND);
        rdReg(xfd_pkg::SFR_KEY, 8'h02);
        core.set_pgm(1'b1, 1'b0);
        core.mv(1'b1, 1'b0, 16'h1405, 8'h55);
        chkBit(flashWriteReq, 1'b1);
        chkVal(flashAddr, 16'h1405);
        chkVal({8'h00, flashData}, 16'h0055);
        chkBit(flashErrorReset, 1'b0);
        core.set_pgm(1'b0, 1'b0);
        rdMem(16'h0005, 1'b0, 8'h3c);
        rdReg(xfd_pkg::SFR_KEY, 8'h00);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_FIRST);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_SECOND);
        core.set_pgm(1'b1, 1'b1);
        core.mv(1'b1, 1'b0, 16'h0200, 8'h00);
        chkBit(flashEraseReq, 1'b1);
        chkBit(flashWriteReq, 1'b0);
        // lock has fallen back, so a second attempt is denied
        core.mv(1'b1, 1'b0, 16'h0200, 8'h00);
        chkBit(flashErrorReset, 1'b1);
        chkBit(flashEraseReq, 1'b0);
        rdReg(xfd_pkg::SFR_KEY, 8'h03);
        core.set_pgm(1'b0, 1'b0);
        doReset();
        rdReg(xfd_pkg::SFR_KEY, 8'h00);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_SECOND);
        rdReg(xfd_pkg::SFR_KEY, 8'h03);
        doReset();
        rdReg(xfd_pkg::SFR_KEY, 8'h00);
        rdReg(xfd_pkg::SFR_TIMING, 8'h80);
        // a key write while open, and a wrong second key, both hard lock
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_FIRST);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_SECOND);
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_FIRST);
        rdReg(xfd_pkg::SFR_KEY, 8'h03);
        doReset();
        core.sfr_wr(xfd_pkg::SFR_KEY, xfd_pkg::KEY_FIRST);
        core.sfr_wr(xfd_pkg::SFR_KEY, 8'h00);
        rdReg(xfd_pkg::SFR_KEY, 8'h03);
        reportAndStop();
    end
endmodule
